// file: hw/lcs_consts.vh
// Constants for the lithium charge cycle sequencer
// How it works
// R1: Each cycle starts with 1mA presence test
// R2: Unstable voltage gets brief charge, range check
// R3: Open thermistor faults; detection fault alert maskable
// R4: Soft-start ramps current DAC, one step/400us
// R5: Charge-time timer from soft-start; overrun faults
// R6: Time fault exits below 35% charge voltage
// R7: Timer cleared on timer or taper termination
// R8: Suspend causes win from every state
// R9: Deep discharge: tenth current, precondition flag
// R10: Leave precharge above 15082, flag CC-CV
// R11: Peak current mode below 2.4V sense
// R12: Iron-phosphate never preconditions
// R13: Iron-phosphate nonzero offset starts absorb phase, flagged
// R14: Absorb target clamped; reaching it flags CV
// R15: Input limits pull current down, flagged
// R16: Absorb ends on time or taper
// R17: CV ends by time, taper, or never
// R18: One-second tick plus 400us ramp tick
`ifndef LCS_CONSTS_VH
`define LCS_CONSTS_VH

`define LCS_CLK_MHZ 50
`define LCS_SEC_US 1000000
`define LCS_RAMP_US 400
`define LCS_DET_SECS 16'h0003
`define LCS_OS_SECS 16'h0002
`define LCS_PRE_ENTER 16'h39E6
`define LCS_PRE_EXIT 16'h3AEA
`define LCS_DET_TOL 16'h0040
`define LCS_OS_MIN 16'h2000
`define LCS_OS_MAX 16'h6000
`define LCS_ABSORB_MAX 5'h1F
`define LCS_PCT35_NUM 5'h07
`define LCS_PCT35_DEN 5'h14
`define LCS_MIN_CURRENT 5'h01

`endif

// file: hw/lcs_ticks.v
// Free-running one-second and soft-start ramp tick generator
`timescale 1ns/1ns
module lcs_ticks #(
  parameter SEC_CYCLES = 50000000,
  parameter RAMP_CYCLES = 20000
) (
  input wire i_clk,
  input wire i_sys_rst,
  output reg o_sec_tick,
  output reg o_ramp_tick
);
  reg [25:0] sec_cnt_q;
  reg [15:0] ramp_cnt_q;

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sec_cnt_q <= 26'h0000000;
      ramp_cnt_q <= 16'h0000;
      o_sec_tick <= 1'b0;
      o_ramp_tick <= 1'b0;
    end else begin
      o_sec_tick <= (sec_cnt_q == SEC_CYCLES[25:0] - 26'h0000001);
      o_ramp_tick <= (ramp_cnt_q == RAMP_CYCLES[15:0] - 16'h0001);
      if (sec_cnt_q == SEC_CYCLES[25:0] - 26'h0000001) begin
        sec_cnt_q <= 26'h0000000;
      end else begin
        sec_cnt_q <= sec_cnt_q + 26'h0000001;
      end
      if (ramp_cnt_q == RAMP_CYCLES[15:0] - 16'h0001) begin
        ramp_cnt_q <= 16'h0000;
      end else begin
        ramp_cnt_q <= ramp_cnt_q + 16'h0001;
      end
    end
  end
endmodule

// file: hw/lcs_sequencer.v
// Charge cycle state machine for lithium-ion and iron-phosphate packs
`timescale 1ns/1ns
`include "lcs_consts.vh"
module lcs_sequencer #(
  parameter SEC_CYCLES = `LCS_SEC_US * `LCS_CLK_MHZ,
  parameter RAMP_CYCLES = `LCS_RAMP_US * `LCS_CLK_MHZ
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_chem_iron_phosphate,
  input wire i_programmable,
  input wire i_suspend_req,
  input wire i_system_fault,
  input wire i_vin_near_bat,
  input wire i_thermistor_open,
  input wire i_sense_above_2v6,
  input wire i_sense_below_2v4,
  input wire i_cv_reached,
  input wire i_input_limit_hit,
  input wire i_undervoltage_feedback_pin,
  input wire i_det_alert_en,
  input wire i_taper_term_en,
  input wire [15:0] i_filtered_battery_voltage,
  input wire [15:0] i_battery_current_reading,
  input wire [15:0] i_vcharge_reading,
  input wire [15:0] i_taper_threshold,
  input wire [4:0] i_charge_current_target,
  input wire [4:0] i_vcharge_setting,
  input wire [4:0] i_absorb_voltage_offset,
  input wire [15:0] i_max_charge_time,
  input wire [15:0] i_max_cv_time,
  input wire [15:0] i_max_absorb_time,
  output reg [4:0] o_charge_current_dac,
  output reg [4:0] o_vcharge_dac,
  output reg o_detect_load,
  output reg o_charger_on,
  output reg o_peak_current_mode,
  output reg o_precondition_flag,
  output reg o_ccv_phase_flag,
  output reg o_absorb_flag,
  output reg o_constant_voltage_flag,
  output reg o_input_limit_flag,
  output reg o_input_uv_flag,
  output reg o_detect_fault,
  output reg o_battery_open_fault,
  output wire o_detect_alert,
  output reg o_charge_time_fault,
  output reg o_suspended,
  output reg o_terminated
);
  localparam [9:0] ST_SUSP = 10'h001;
  localparam [9:0] ST_DETECT = 10'h002;
  localparam [9:0] ST_OPENSHORT = 10'h004;
  localparam [9:0] ST_SOFT = 10'h008;
  localparam [9:0] ST_PRE = 10'h010;
  localparam [9:0] ST_ABSORB = 10'h020;
  localparam [9:0] ST_CCCV = 10'h040;
  localparam [9:0] ST_TERM = 10'h080;
  localparam [9:0] ST_TFAULT = 10'h100;
  localparam [9:0] ST_DFAULT = 10'h200;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Comparator and fault pins are asynchronous to the system clock
  reg [7:0] meta_q;
  reg [7:0] pin_q;
  wire fault_s = pin_q[0];
  wire near_s = pin_q[1];
  wire ntc_open_s = pin_q[2];
  wire above_s = pin_q[3];
  wire below_s = pin_q[4];
  wire cv_s = pin_q[5];
  wire iin_s = pin_q[6];
  wire uv_s = pin_q[7];

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      meta_q <= 8'h00;
      pin_q <= 8'h00;
    end else begin
      meta_q <= {i_undervoltage_feedback_pin, i_input_limit_hit, i_cv_reached,
                 i_sense_below_2v4, i_sense_above_2v6, i_thermistor_open,
                 i_vin_near_bat, i_system_fault};
      pin_q <= meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ticks

  wire sec_tick;
  wire ramp_tick;

  lcs_ticks #(
    .SEC_CYCLES(SEC_CYCLES),
    .RAMP_CYCLES(RAMP_CYCLES)
  ) u_ticks (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .o_sec_tick(sec_tick), // R18
    .o_ramp_tick(ramp_tick) // R18
  );

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function [15:0] abs_diff;
    input [15:0] a;
    input [15:0] b;
    begin
      abs_diff = (a > b) ? a - b : b - a;
    end
  endfunction

  function in_charge;
    input [9:0] st;
    begin
      in_charge = |(st & (ST_SOFT | ST_PRE | ST_ABSORB | ST_CCCV));
    end
  endfunction

  reg [9:0] state_q;
  reg [9:0] state_d;
  reg [15:0] phase_secs_q;
  reg [16:0] charge_secs_q;
  reg [15:0] cv_secs_q;
  reg [15:0] vbat_start_q;

  wire [15:0] vbat = i_filtered_battery_voltage;
  wire suspend_cause = i_suspend_req | fault_s | near_s; // R8
  wire [4:0] pre_current = i_charge_current_target / 5'h0A; // R9
  // Precharge only once the sense pin is clear of peak current mode
  wire deep_low = ~i_chem_iron_phosphate & (vbat < `LCS_PRE_ENTER) & above_s; // R9 R12
  wire taper_hit = cv_s & (i_battery_current_reading < i_taper_threshold);
  wire taper_term = i_taper_term_en & i_programmable & taper_hit; // R17
  // Iron-phosphate may disable time termination with a zero limit
  wire time_term_en = ~i_chem_iron_phosphate | (i_max_cv_time != 16'h0000); // R17
  wire cv_expired = time_term_en & (cv_secs_q >= i_max_cv_time);
  wire [20:0] vbat_x20 = vbat * `LCS_PCT35_DEN;
  wire [20:0] vchg_x7 = i_vcharge_reading * `LCS_PCT35_NUM;
  wire below_35pct = vbat_x20 < vchg_x7; // R6
  wire timer_over = charge_secs_q > {1'b0, i_max_charge_time}; // R5
  wire absorb_req = i_chem_iron_phosphate & (i_absorb_voltage_offset != 5'h00); // R13
  wire [5:0] absorb_sum = {1'b0, i_vcharge_setting} + {1'b0, i_absorb_voltage_offset};
  wire [4:0] absorb_code = (absorb_sum > {1'b0, `LCS_ABSORB_MAX}) ?
                           `LCS_ABSORB_MAX : absorb_sum[4:0]; // R14
  wire [4:0] soft_goal = deep_low ? pre_current : i_charge_current_target;

  assign o_detect_alert = o_detect_fault & i_det_alert_en; // R3

  ////////////////////////////////////////////////////////////////////////
  // State machine

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SUSP: begin
        state_d = ST_DETECT;
      end
      ST_DETECT: begin
        if (ntc_open_s) begin
          state_d = ST_DFAULT; // R3
        end else if (sec_tick && phase_secs_q == `LCS_DET_SECS - 16'h0001) begin
          if (abs_diff(vbat, vbat_start_q) <= `LCS_DET_TOL) begin
            state_d = ST_SOFT; // R2
          end else begin
            state_d = ST_OPENSHORT; // R2
          end
        end
      end
      ST_OPENSHORT: begin
        if (sec_tick && phase_secs_q == `LCS_OS_SECS - 16'h0001) begin
          if (vbat >= `LCS_OS_MIN && vbat <= `LCS_OS_MAX) begin
            state_d = ST_SOFT; // R2
          end else begin
            state_d = ST_DFAULT; // R2
          end
        end
      end
      ST_SOFT: begin
        if (o_charge_current_dac == soft_goal) begin
          if (absorb_req) begin
            state_d = ST_ABSORB; // R13
          end else if (deep_low) begin
            state_d = ST_PRE; // R9
          end else begin
            state_d = ST_CCCV; // R12
          end
        end
      end
      ST_PRE: begin
        if (vbat > `LCS_PRE_EXIT) begin
          state_d = ST_CCCV; // R10
        end
      end
      ST_ABSORB: begin
        if (phase_secs_q >= i_max_absorb_time || taper_hit) begin
          state_d = ST_CCCV; // R16
        end
      end
      ST_CCCV: begin
        if (cv_expired || taper_term) begin
          state_d = ST_TERM; // R17
        end
      end
      ST_TERM: begin
        state_d = ST_TERM;
      end
      ST_TFAULT: begin
        if (below_35pct) begin
          state_d = ST_DETECT; // R6
        end
      end
      ST_DFAULT: begin
        state_d = ST_DFAULT;
      end
      default: begin
        state_d = ST_SUSP;
      end
    endcase
    // Late overrides: safety timer beats phase exits, suspend beats all
    if (in_charge(state_q) && timer_over) begin
      state_d = ST_TFAULT; // R5
    end
    if (suspend_cause) begin
      state_d = ST_SUSP; // R8
    end
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_q <= ST_SUSP;
      phase_secs_q <= 16'h0000;
      charge_secs_q <= 17'h00000;
      cv_secs_q <= 16'h0000;
      vbat_start_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        phase_secs_q <= 16'h0000;
      end else if (sec_tick && phase_secs_q != 16'hFFFF) begin
        phase_secs_q <= phase_secs_q + 16'h0001;
      end
      if (state_q != ST_DETECT) begin
        vbat_start_q <= vbat; // R1
      end
      // New cycle or termination restarts the safety timer
      if (state_d == ST_DETECT || state_d == ST_TERM) begin
        charge_secs_q <= 17'h00000; // R6 R7
      end else if (in_charge(state_q) && sec_tick && !charge_secs_q[16]) begin
        charge_secs_q <= charge_secs_q + 17'h00001; // R5
      end
      if (state_q != ST_CCCV || !cv_s) begin
        cv_secs_q <= 16'h0000;
      end else if (sec_tick && cv_secs_q != 16'hFFFF) begin
        cv_secs_q <= cv_secs_q + 16'h0001; // R17
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Current DAC ramp and regulation

  reg [4:0] goal;
  always @* begin
    case (state_q)
      ST_SOFT: goal = soft_goal;
      ST_PRE: goal = pre_current; // R9
      ST_ABSORB: goal = i_charge_current_target;
      ST_CCCV: goal = i_charge_current_target; // R10
      default: goal = 5'h00;
    endcase
  end

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_charge_current_dac <= 5'h00;
    end else if (state_q == ST_OPENSHORT) begin
      // Soft-start must begin from zero, not from the check current
      o_charge_current_dac <= (state_d == ST_SOFT) ? 5'h00 : `LCS_MIN_CURRENT; // R2 R4
    end else if (!in_charge(state_q)) begin
      o_charge_current_dac <= 5'h00;
    end else if (ramp_tick) begin
      // Input loops only take current away; they never add any
      if ((iin_s || uv_s) && o_charge_current_dac != 5'h00) begin
        o_charge_current_dac <= o_charge_current_dac - 5'h01; // R15
      end else if (!(iin_s || uv_s) && o_charge_current_dac < goal) begin
        o_charge_current_dac <= o_charge_current_dac + 5'h01; // R4
      end else if (o_charge_current_dac > goal) begin
        o_charge_current_dac <= o_charge_current_dac - 5'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs and flags

  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_vcharge_dac <= 5'h00;
      o_detect_load <= 1'b0;
      o_charger_on <= 1'b0;
      o_peak_current_mode <= 1'b0;
      o_precondition_flag <= 1'b0;
      o_ccv_phase_flag <= 1'b0;
      o_absorb_flag <= 1'b0;
      o_constant_voltage_flag <= 1'b0;
      o_input_limit_flag <= 1'b0;
      o_input_uv_flag <= 1'b0;
      o_detect_fault <= 1'b0;
      o_battery_open_fault <= 1'b0;
      o_charge_time_fault <= 1'b0;
      o_suspended <= 1'b1;
      o_terminated <= 1'b0;
    end else begin
      o_vcharge_dac <= (state_q == ST_ABSORB) ? absorb_code : i_vcharge_setting; // R14 R16
      o_detect_load <= (state_q == ST_DETECT); // R1
      o_charger_on <= in_charge(state_q) || state_q == ST_OPENSHORT;
      // Hysteresis between the two sense thresholds
      if (below_s) begin
        o_peak_current_mode <= 1'b1; // R11
      end else if (above_s) begin
        o_peak_current_mode <= 1'b0; // R11
      end
      o_precondition_flag <= (state_q == ST_PRE); // R9
      o_ccv_phase_flag <= (state_q == ST_CCCV); // R10
      o_absorb_flag <= (state_q == ST_ABSORB); // R13
      o_constant_voltage_flag <= in_charge(state_q) & cv_s; // R14
      o_input_limit_flag <= in_charge(state_q) & iin_s; // R15
      o_input_uv_flag <= in_charge(state_q) & uv_s; // R15
      o_detect_fault <= (state_q == ST_DFAULT); // R3
      // Open fault holds through the fault state, clears once it is left
      if (state_q == ST_DETECT && ntc_open_s) begin
        o_battery_open_fault <= 1'b1; // R3
      end else if (state_q != ST_DFAULT) begin
        o_battery_open_fault <= 1'b0;
      end
      o_charge_time_fault <= (state_q == ST_TFAULT); // R5
      o_suspended <= (state_q == ST_SUSP); // R8
      o_terminated <= (state_q == ST_TERM); // R7
    end
  end
endmodule

// file: sim/lcs_sva.sv
// Port-level assertions for the charge cycle sequencer
`timescale 1ns/1ns
module lcs_sva (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_chem_iron_phosphate,
  input wire i_suspend_req,
  input wire i_det_alert_en,
  input wire [4:0] i_charge_current_target,
  input wire [4:0] i_vcharge_setting,
  input wire [4:0] i_absorb_voltage_offset,
  input wire [4:0] o_charge_current_dac,
  input wire [4:0] o_vcharge_dac,
  input wire o_detect_load,
  input wire o_charger_on,
  input wire o_precondition_flag,
  input wire o_ccv_phase_flag,
  input wire o_absorb_flag,
  input wire o_detect_fault,
  input wire o_detect_alert,
  input wire o_charge_time_fault,
  input wire o_suspended
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire [5:0] abs_sum = i_vcharge_setting + i_absorb_voltage_offset;
  // Absorb target saturates at the top code
  wire [4:0] abs_goal = abs_sum[5] ? 5'h1F : abs_sum[4:0];
  //////////////////////////////////////////////////////////////////////
  property p_alert;
    o_detect_alert == (o_detect_fault && i_det_alert_en);
  endproperty
  a_alert: assert property (p_alert) else $error("alert not fault and mask");
  // Up-steps are checked in soft-start only; limit loops may move the code elsewhere
  property p_ramp;
    $past(o_charger_on) && !o_precondition_flag && !o_ccv_phase_flag && !o_absorb_flag
      && o_charge_current_dac > $past(o_charge_current_dac)
      |-> o_charge_current_dac == $past(o_charge_current_dac) + 5'h01;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp step not one");
  property p_pre;
    $rose(o_precondition_flag) |-> o_charge_current_dac == i_charge_current_target / 5'h0A;
  endproperty
  a_pre: assert property (p_pre) else $error("precharge current wrong");
  property p_iron;
    i_chem_iron_phosphate && $past(i_chem_iron_phosphate, 3) |-> !o_precondition_flag;
  endproperty
  a_iron: assert property (p_iron) else $error("iron pack preconditioned");
  property p_absorb;
    $rose(o_absorb_flag) |-> o_vcharge_dac == abs_goal;
  endproperty
  a_absorb: assert property (p_absorb) else $error("absorb target wrong");
  property p_susp;
    i_suspend_req |-> ##[1:3] o_suspended;
  endproperty
  a_susp: assert property (p_susp) else $error("suspend late");
  property p_load;
    $fell(o_suspended) |-> o_detect_load;
  endproperty
  a_load: assert property (p_load) else $error("cycle without presence load");
  property p_ctf;
    o_charge_time_fault && $past(o_charge_time_fault) |-> !o_charger_on;
  endproperty
  a_ctf: assert property (p_ctf) else $error("charging in time fault");
endmodule

// file: sim/lcs_batt_model.sv
// Behavioural pack: voltage rise, taper current and charge-voltage reach
`timescale 1ns/1ns
module lcs_batt_model (
  input wire i_clk,
  input wire i_charger_on,
  input wire i_load,
  input wire i_jitter,
  input wire [15:0] i_start,
  input wire [15:0] i_rate,
  input wire [15:0] i_cv_level,
  output wire [15:0] o_vbat,
  output wire [15:0] o_battery_current_reading,
  output wire o_cv_reached
);
  logic [15:0] v_q;
  logic [7:0] cnt_q = 8'h00;
  always @(posedge i_clk) begin
    cnt_q <= cnt_q + 8'h01;
    if (i_load) begin
      v_q <= i_start;
    end else if (i_charger_on && v_q < i_cv_level) begin
      v_q <= v_q + i_rate;
    end
  end
  // Reading wanders so the presence test sees an unstable pack
  assign o_vbat = i_jitter ? v_q + {6'h00, cnt_q, 2'h0} : v_q;
  assign o_cv_reached = v_q >= i_cv_level;
  assign o_battery_current_reading = !i_charger_on ? 16'h0000 : o_cv_reached ? 16'h0040 : 16'h0800;
endmodule

// file: sim/tb_lithium_charge_sequencer.sv
// Bench for the charge cycle sequencer with a behavioural pack
`timescale 1ns/1ns
module tb_lithium_charge_sequencer;
  localparam int SEC = 200;
  localparam int LD = 2, CON = 3, PK = 4, PRE = 5, CCV = 6, ABS = 7, CV = 8, ILF = 9;
  localparam int UVF = 10, DF = 11, OF = 12, AL = 13, CTF = 14, SP = 15, TM = 16, TV = 17;
  typedef struct {int f; logic [4:0] v;} lcs_note_t;
  lcs_note_t q[$];
  event ev;
  int miscompares = 0, comparisons = 0, n;
  integer seed = 32'hA7ED;
  logic tv = 0, ld = 1, jit = 0;
  logic [15:0] vst = 16'h4000, rate = 16'h0000, cvl = 16'h5000;
  logic i_clk = 0, i_sys_rst = 1, i_chem_iron_phosphate = 0, i_programmable = 0;
  logic i_suspend_req = 0, i_system_fault = 0, i_vin_near_bat = 0, i_thermistor_open = 0;
  logic i_sense_above_2v6 = 1, i_sense_below_2v4 = 0, i_input_limit_hit = 0;
  logic i_undervoltage_feedback_pin = 0, i_det_alert_en = 1, i_taper_term_en = 0;
  logic [15:0] i_vcharge_reading = 16'h6000, i_taper_threshold = 16'h0100;
  logic [15:0] i_max_charge_time = 16'h0064, i_max_cv_time = 16'h0002;
  logic [15:0] i_max_absorb_time = 16'h0064;
  logic [4:0] i_charge_current_target = 5'h0A, i_vcharge_setting = 5'h0A;
  logic [4:0] i_absorb_voltage_offset = 5'h00;
  wire [15:0] i_filtered_battery_voltage, i_battery_current_reading;
  wire [4:0] o_charge_current_dac, o_vcharge_dac;
  wire i_cv_reached, o_detect_load, o_charger_on, o_peak_current_mode, o_precondition_flag;
  wire o_ccv_phase_flag, o_absorb_flag, o_constant_voltage_flag, o_input_limit_flag;
  wire o_input_uv_flag, o_detect_fault, o_battery_open_fault, o_detect_alert;
  wire o_charge_time_fault, o_suspended, o_terminated;
  wire [24:0] ob = {o_terminated, o_suspended, o_charge_time_fault, o_detect_alert,
    o_battery_open_fault, o_detect_fault, o_input_uv_flag, o_input_limit_flag,
    o_constant_voltage_flag, o_absorb_flag, o_ccv_phase_flag, o_precondition_flag,
    o_peak_current_mode, o_charger_on, o_detect_load, o_vcharge_dac, o_charge_current_dac};
  lcs_sequencer #(.SEC_CYCLES(SEC), .RAMP_CYCLES(10)) DUT (.*);
  lcs_batt_model u_pack (.i_clk(i_clk), .i_charger_on(o_charger_on), .i_load(ld),
    .i_jitter(jit), .i_start(vst), .i_rate(rate), .i_cv_level(cvl),
    .o_vbat(i_filtered_battery_voltage), .o_battery_current_reading(i_battery_current_reading),
    .o_cv_reached(i_cv_reached));
  always #10 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] fv(int f);
    if (f == 0) return ob[4:0];
    if (f == 1) return ob[9:5];
    if (f == TV) return {4'h0, tv};
    return {4'h0, ob[f + 8]};
  endfunction
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Waits for the monitor so later stimulus cannot disturb the sample
  task automatic chk(int f, logic [4:0] v);
    q.push_back('{f, v});
    ->ev;
    wait (q.size() == 0);
  endtask
  always @(ev) begin
    lcs_note_t e;
    while (q.size() > 0) begin
      e = q.pop_front();
      comparisons++;
      if (fv(e.f) !== e.v) begin
        miscompares++;
        $display("ERROR %0t field %0d got %0h want %0h", $time, e.f, fv(e.f), e.v);
      end
    end
  end
  task automatic wt(int f, logic [4:0] v, int lim);
    n = 0;
    while (fv(f) !== v && n < lim) begin
      @(negedge i_clk);
      n++;
    end
    chk(f, v);
  endtask
  task automatic rst(logic chem, logic [15:0] v);
    i_sys_rst = 1;
    i_chem_iron_phosphate = chem;
    vst = v;
    ld = 1;
    repeat (4) @(negedge i_clk);
    i_sys_rst = 0;
    ld = 0;
    repeat (2) @(negedge i_clk);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    i_charge_current_target = 5'h0A + {1'b0, 4'($random(seed))};
    rst(0, 16'h4000);
    chk(LD, 1);
    chk(SP, 0);
    wt(LD, 0, 5 * SEC);
    tv = n >= 2 * SEC - 10 && n <= 4 * SEC;
    chk(TV, 1);
    wt(0, i_charge_current_target, 400);
    tv = n >= 10 * i_charge_current_target - 15 && n <= 10 * i_charge_current_target + 10;
    chk(TV, 1);
    wt(CCV, 1, 50);
    i_sense_below_2v4 = 1;
    i_sense_above_2v6 = 0;
    wt(PK, 1, 10);
    i_sense_below_2v4 = 0;
    repeat (10) @(negedge i_clk);
    chk(PK, 1);
    i_sense_above_2v6 = 1;
    wt(PK, 0, 10);
    rate = 16'h0010;
    wt(TM, 1, 5 * SEC);
    chk(CTF, 0);
    $display("li-ion cycle done");
    rate = 16'h0001;
    rst(0, 16'h3000);
    wt(PRE, 1, 6 * SEC);
    chk(0, 5'(i_charge_current_target / 5'h0A));
    wt(CCV, 1, 20 * SEC);
    tv = i_filtered_battery_voltage > 16'h3AEA;
    chk(TV, 1);
    $display("precharge done");
    rate = 16'h0000;
    i_max_charge_time = 16'h0001;
    rst(0, 16'h4000);
    wt(CTF, 1, 8 * SEC);
    chk(CON, 0);
    vst = 16'h2000;
    ld = 1;
    @(negedge i_clk);
    ld = 0;
    wt(LD, 1, 10);
    chk(CTF, 0);
    vst = 16'h4000;
    ld = 1;
    @(negedge i_clk);
    ld = 0;
    wt(CON, 1, 5 * SEC);
    chk(0, 5'h01);
    wt(CTF, 1, 8 * SEC);
    for (int c = 0; c < 3; c++) begin
      {i_suspend_req, i_system_fault, i_vin_near_bat} = 3'h1 << c;
      wt(SP, 1, 8);
      {i_suspend_req, i_system_fault, i_vin_near_bat} = 3'h0;
      wt(LD, 1, 8);
    end
    $display("time fault done");
    i_max_charge_time = 16'h0064;
    i_max_cv_time = 16'h0064;
    i_absorb_voltage_offset = 5'h1C;
    i_programmable = 1;
    i_taper_term_en = 1;
    rst(1, 16'h3000);
    wt(ABS, 1, 6 * SEC);
    chk(PRE, 0);
    chk(0, i_charge_current_target);
    chk(1, 5'h1F);
    i_input_limit_hit = 1;
    i_undervoltage_feedback_pin = 1;
    wt(ILF, 1, 10);
    wt(UVF, 1, 10);
    repeat (30) @(negedge i_clk);
    tv = o_charge_current_dac < i_charge_current_target;
    chk(TV, 1);
    i_input_limit_hit = 0;
    i_undervoltage_feedback_pin = 0;
    rate = 16'h0004;
    wt(CV, 1, 3000);
    wt(ABS, 0, 20);
    wt(CCV, 1, 5);
    wt(1, i_vcharge_setting, 5);
    wt(TM, 1, 20);
    $display("absorb done");
    i_programmable = 0;
    rate = 16'h0000;
    i_thermistor_open = 1;
    rst(0, 16'h4000);
    wt(DF, 1, 5 * SEC);
    chk(OF, 1);
    chk(AL, 1);
    i_det_alert_en = 0;
    @(negedge i_clk);
    chk(AL, 0);
    i_det_alert_en = 1;
    i_thermistor_open = 0;
    jit = 1;
    rst(0, 16'h7000);
    wt(DF, 1, 10 * SEC);
    chk(OF, 0);
    rst(0, 16'h4000);
    wt(CCV, 1, 10 * SEC);
    $display("detection done");
    conclude();
  end
  initial begin
    repeat (60000) @(posedge i_clk);
    miscompares++;
    conclude();
  end
endmodule
bind lcs_sequencer lcs_sva u_sva (.*);
